// ### rtl/soi_serial_one_irq.sv
`timescale 1ns/1ps
`include "soi_defines.svh"
module soi_serial_one_irq (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave.
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  // Event strobes, one-cycle pulses on clk.
  input  wire logic        parity_error_event,
  input  wire logic        frame_error_event,
  input  wire logic        tx_buffer_b_unloaded,
  input  wire logic        tx_buffer_a_unloaded,
  input  wire logic        rx_buffer_b_unloaded,
  input  wire logic        rx_buffer_a_unloaded,
  input  wire logic        i2c_nack_event,
  input  wire logic        command_finished_event,
  input  wire logic        transmit_finished_event,
  input  wire logic        receive_finished_event,
  input  wire logic        transmit_underrun_event,
  input  wire logic        receive_overrun_event,
  input  wire logic        transmitter_idle_event,
  input  wire logic        transmit_space_event,
  input  wire logic        receive_valid_event,
  output logic             irq
);
  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rst_q_n;

  // Release is synchronised so the bus and flag flops leave reset on the same edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_q_n = rst_sync[1];

  // ****************************************
  // Bus slave state
  // ****************************************
  typedef struct packed {
    soi_pkg::soi_bus_state_t bus;
    logic [31:0]             rdata;
    logic [1:0]              resp;
  } soi_top_state_t;

  soi_top_state_t state;
  soi_top_state_t next_state;
  soi_event_if    ev ();

  logic        req;
  logic        hit_pend;
  logic        hit_en;
  logic [15:0] wmask;

  // Lane mask from byte enables; only the low two lanes hold register bits.
  function automatic logic [15:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  assign req      = avs_read | avs_write;
  assign hit_pend = (avs_address == `SOI_ADDR_PENDING);
  assign hit_en   = (avs_address == `SOI_ADDR_ENABLE);
  assign wmask    = lane_mask(avs_byteenable);

  // Events placed at their flag positions.
  always_comb begin
    ev.events = 16'h0000;
    ev.events[`SOI_BIT_PARITY]   = parity_error_event;
    ev.events[`SOI_BIT_FRAME]    = frame_error_event;
    ev.events[`SOI_BIT_TXB_ULD]  = tx_buffer_b_unloaded;
    ev.events[`SOI_BIT_TXA_ULD]  = tx_buffer_a_unloaded;
    ev.events[`SOI_BIT_RXB_ULD]  = rx_buffer_b_unloaded;
    ev.events[`SOI_BIT_RXA_ULD]  = rx_buffer_a_unloaded;
    ev.events[`SOI_BIT_NACK]     = i2c_nack_event;
    ev.events[`SOI_BIT_CMDFIN]   = command_finished_event;
    ev.events[`SOI_BIT_TXFIN]    = transmit_finished_event;
    ev.events[`SOI_BIT_RXFIN]    = receive_finished_event;
    ev.events[`SOI_BIT_UNDERRUN] = transmit_underrun_event;
    ev.events[`SOI_BIT_OVERRUN]  = receive_overrun_event;
    ev.events[`SOI_BIT_TXIDLE]   = transmitter_idle_event;
    ev.events[`SOI_BIT_TXFREE]   = transmit_space_event;
    ev.events[`SOI_BIT_RXVALID]  = receive_valid_event;
  end

  // Writes act in the cycle waitrequest is low, which is the answer cycle.
  always_comb begin
    ev.clear        = 16'h0000;
    ev.enable_we    = 1'b0;
    ev.enable_wdata = (ev.enable & ~wmask) | (avs_writedata[15:0] & wmask);
    if (state.bus == soi_pkg::SOI_ANSWER && avs_write) begin
      if (hit_pend) begin
        ev.clear = avs_writedata[15:0] & wmask; // Write one to clear.
      end
      if (hit_en) begin
        ev.enable_we = 1'b1;
      end
    end
  end

  // One wait cycle, then an answer; unmapped addresses read zero with error.
  always_comb begin
    next_state = state;
    case (state.bus)
      soi_pkg::SOI_IDLE: begin
        if (req) begin
          next_state.bus = soi_pkg::SOI_ANSWER;
        end
      end
      soi_pkg::SOI_ANSWER: begin
        next_state.bus = soi_pkg::SOI_IDLE;
      end
      default: begin
        next_state.bus = soi_pkg::SOI_IDLE;
      end
    endcase
    if (state.bus == soi_pkg::SOI_IDLE && req) begin
      next_state.resp  = (hit_pend | hit_en) ? 2'h0 : 2'h2;
      next_state.rdata = 32'h0000_0000;
      if (avs_read && hit_pend) begin
        next_state.rdata = {16'h0000, ev.pending};
      end else if (avs_read && hit_en) begin
        next_state.rdata = {16'h0000, ev.enable};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state <= '{bus: soi_pkg::SOI_IDLE, rdata: 32'h0000_0000, resp: 2'h0};
    end else begin
      state <= next_state;
    end
  end

  assign avs_waitrequest = req && (state.bus != soi_pkg::SOI_ANSWER);
  assign avs_readdata    = state.rdata;
  assign avs_response    = state.resp;
  assign irq             = ev.irq;

  soi_flag_regs u_flags (
    .clk   (clk),
    .rst_n (rst_q_n),
    .ev    (ev.regs)
  );

  chk_wait_one: assert property (@(posedge clk) disable iff (!rst_q_n)
    (req && state.bus == soi_pkg::SOI_IDLE) |-> avs_waitrequest) else $error("no wait cycle");
  chk_irq_out: assert property (@(posedge clk) disable iff (!rst_q_n)
    irq == ev.irq) else $error("irq not passed");
  cov_read_pend: cover property (@(posedge clk) disable iff (!rst_q_n)
    avs_read && hit_pend && !avs_waitrequest);
  cov_clear: cover property (@(posedge clk) disable iff (!rst_q_n) |ev.clear);
endmodule

// ### rtl/soi_defines.svh
`ifndef SOI_DEFINES_SVH
`define SOI_DEFINES_SVH
// Byte addresses of the two registers on the register bus.
`define SOI_ADDR_PENDING 16'h460C
`define SOI_ADDR_ENABLE  16'h4624
// Register width and reset value.
`define SOI_REG_W        16
`define SOI_RESET_VAL    16'h0000
// Bits that exist; bit 15 always reads zero.
`define SOI_IMPL_MASK    16'h7FFF
// Event bit positions.
`define SOI_BIT_PARITY   14
`define SOI_BIT_FRAME    13
`define SOI_BIT_TXB_ULD  12
`define SOI_BIT_TXA_ULD  11
`define SOI_BIT_RXB_ULD  10
`define SOI_BIT_RXA_ULD  9
`define SOI_BIT_NACK     8
`define SOI_BIT_CMDFIN   7
`define SOI_BIT_TXFIN    6
`define SOI_BIT_RXFIN    5
`define SOI_BIT_UNDERRUN 4
`define SOI_BIT_OVERRUN  3
`define SOI_BIT_TXIDLE   2
`define SOI_BIT_TXFREE   1
`define SOI_BIT_RXVALID  0
`endif

// ### rtl/soi_pkg.sv
package soi_pkg;
  // Bus answer state of the slave.
  typedef enum logic [1:0] {
    SOI_IDLE,
    SOI_ANSWER
  } soi_bus_state_t;
  // Latched event word.
  typedef logic [15:0] soi_word_t;
endpackage

// ### rtl/soi_event_if.sv
`timescale 1ns/1ps
// Carries the event strobes and the pending/enable pair between modules.
interface soi_event_if;
  logic [15:0] events;
  logic [15:0] pending;
  logic [15:0] enable;
  logic [15:0] clear;
  logic [15:0] enable_wdata;
  logic        enable_we;
  logic        irq;
  modport regs (input events, input clear, input enable_wdata, input enable_we,
                output pending, output enable, output irq);
  modport ctrl (output events, output clear, output enable_wdata, output enable_we,
                input pending, input enable, input irq);
endinterface

// ### rtl/soi_flag_regs.sv
`timescale 1ns/1ps
`include "soi_defines.svh"
// Pending flags and enable bits with the gated interrupt output.
module soi_flag_regs (
  input wire logic clk,
  input wire logic rst_n,
  soi_event_if.regs ev
);
  typedef struct packed {
    logic [15:0] pending;
    logic [15:0] enable;
  } soi_flag_state_t;

  soi_flag_state_t state;
  soi_flag_state_t next_state;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_comb begin
    next_state = state;
    next_state.pending = ((state.pending & ~ev.clear) | ev.events) & `SOI_IMPL_MASK;
    if (ev.enable_we) begin
      next_state.enable = ev.enable_wdata & `SOI_IMPL_MASK;
    end
  end

  // Registers the state copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{pending: `SOI_RESET_VAL, enable: `SOI_RESET_VAL};
    end else begin
      state <= next_state;
    end
  end

  assign ev.pending = state.pending;
  assign ev.enable  = state.enable;
  // Enable bits gate each pending flag onto the one request line.
  assign ev.irq     = |(state.pending & state.enable);

  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ((|(ev.events & ev.enable)) && !ev.enable_we) |=> ev.irq) else $error("enabled event gave no irq");
  chk_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_PARITY] |=> ev.pending[`SOI_BIT_PARITY]) else $error("parity flag lost");
  chk_txa_set: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_TXA_ULD] |=> ev.pending[`SOI_BIT_TXA_ULD]) else $error("tx A flag lost");
  chk_rxa_set: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_RXA_ULD] |=> ev.pending[`SOI_BIT_RXA_ULD]) else $error("rx A flag lost");
  chk_idle_set: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_TXIDLE] |=> ev.pending[`SOI_BIT_TXIDLE]) else $error("idle flag lost");
  chk_free_set: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_TXFREE] |=> ev.pending[`SOI_BIT_TXFREE]) else $error("free flag lost");
  chk_rxval_set: assert property (@(posedge clk) disable iff (!rst_n)
    ev.events[`SOI_BIT_RXVALID] |=> ev.pending[`SOI_BIT_RXVALID]) else $error("rx valid flag lost");
  chk_bit15_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !ev.pending[15] && !ev.enable[15]) else $error("bit 15 set");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.pending[`SOI_BIT_FRAME] && !ev.clear[`SOI_BIT_FRAME]) |=> ev.pending[`SOI_BIT_FRAME])
    else $error("frame flag dropped");
  chk_txb_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.pending[`SOI_BIT_TXB_ULD] && ev.enable[`SOI_BIT_TXB_ULD]) |-> ev.irq)
    else $error("tx B not gated");
  chk_txa_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.pending[`SOI_BIT_TXA_ULD] && ev.enable[`SOI_BIT_TXA_ULD]) |-> ev.irq)
    else $error("tx A not gated");
  chk_rxb_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.pending[`SOI_BIT_RXB_ULD] && ev.enable[`SOI_BIT_RXB_ULD]) |-> ev.irq)
    else $error("rx B not gated");
  chk_rxa_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (ev.pending[`SOI_BIT_RXA_ULD] && ev.enable[`SOI_BIT_RXA_ULD]) |-> ev.irq)
    else $error("rx A not gated");

  cov_irq_rise: cover property (@(posedge clk) disable iff (!rst_n) $rose(ev.irq));
  cov_set_clear: cover property (@(posedge clk) disable iff (!rst_n)
    |(ev.events & ev.clear));
  cov_irq_fall: cover property (@(posedge clk) disable iff (!rst_n) $fell(ev.irq));
endmodule

// ### verif/serial_one_interrupt_regs_tb_top.sv
`timescale 1ns/1ps
`include "soi_defines.svh"
// ****************************************
// Bench for the serial one event registers.
// ****************************************
module serial_one_interrupt_regs_tb_top;
  logic        clk;
  logic        rst_n;
  logic [15:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [14:0] ev;
  logic        irq;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [15:0] m;
  int          n_mismatch;
  int          total_checks;
  int          cyc;

  // Event vector maps onto the strobes in bit order of the registers.
  soi_serial_one_irq dut_u (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .avs_address             (avs_address),
    .avs_read                (avs_read),
    .avs_write               (avs_write),
    .avs_writedata           (avs_writedata),
    .avs_byteenable          (avs_byteenable),
    .avs_readdata            (avs_readdata),
    .avs_waitrequest         (avs_waitrequest),
    .avs_response            (avs_response),
    .parity_error_event      (ev[14]),
    .frame_error_event       (ev[13]),
    .tx_buffer_b_unloaded    (ev[12]),
    .tx_buffer_a_unloaded    (ev[11]),
    .rx_buffer_b_unloaded    (ev[10]),
    .rx_buffer_a_unloaded    (ev[9]),
    .i2c_nack_event          (ev[8]),
    .command_finished_event  (ev[7]),
    .transmit_finished_event (ev[6]),
    .receive_finished_event  (ev[5]),
    .transmit_underrun_event (ev[4]),
    .receive_overrun_event   (ev[3]),
    .transmitter_idle_event  (ev[2]),
    .transmit_space_event    (ev[1]),
    .receive_valid_event     (ev[0]),
    .irq                     (irq)
  );

  // Free running clock at 50 MHz.
  always #10 clk = ~clk;

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; held until waitrequest is seen low, then one idle edge so strobes never toggle twice.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    if (wr)
      avs_write <= 1'b1;
    else
      avs_read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (n >= 64)
      n_mismatch++;
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 4'hF);
    check(rd, {16'h0000, exp});
  endtask

  // The interrupt is decoded from the registered flags, so one more edge passes before it is looked at.
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    check({31'h00000000, irq}, {31'h00000000, exp});
  endtask

  // One cycle strobe on the chosen events.
  task automatic pulse(input logic [14:0] p);
    ev <= p;
    @(posedge clk);
    ev <= 15'h0000;
    @(posedge clk);
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_address = 16'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    ev = 15'h0000;
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    irq_chk(1'b0);
    rd_chk(`SOI_ADDR_PENDING, 16'h0000);
    rd_chk(`SOI_ADDR_ENABLE, 16'h0000);
    // Each event alone: latched, masked, gated, then cleared by a one.
    for (int i = 0; i < 15; i++) begin
      m = 16'h0001 << i;
      pulse(m[14:0]);
      rd_chk(`SOI_ADDR_PENDING, m);
      irq_chk(1'b0);
      wr(`SOI_ADDR_ENABLE, ~m & 16'h7FFF);
      irq_chk(1'b0);
      wr(`SOI_ADDR_ENABLE, m);
      irq_chk(1'b1);
      wr(`SOI_ADDR_PENDING, ~m);
      rd_chk(`SOI_ADDR_PENDING, m);
      wr(`SOI_ADDR_PENDING, m);
      rd_chk(`SOI_ADDR_PENDING, 16'h0000);
      irq_chk(1'b0);
      wr(`SOI_ADDR_ENABLE, 16'h0000);
    end
    // Bit 15 stays zero, all events at once, and lane masking.
    wr(`SOI_ADDR_ENABLE, 16'hFFFF);
    rd_chk(`SOI_ADDR_ENABLE, 16'h7FFF);
    pulse(15'h7FFF);
    rd_chk(`SOI_ADDR_PENDING, 16'h7FFF);
    wr(`SOI_ADDR_PENDING, 16'hFFFF);
    rd_chk(`SOI_ADDR_PENDING, 16'h0000);
    bus(1'b1, `SOI_ADDR_ENABLE, 16'h0000, 4'h2);
    rd_chk(`SOI_ADDR_ENABLE, 16'h00FF);
    // An unmapped place reads zero, flags an error and ignores writes.
    bus(1'b1, 16'h4600, 16'hFFFF, 4'hF);
    bus(1'b0, 16'h4600, 16'h0000, 4'hF);
    check(rd, 32'h00000000);
    check({30'h00000000, rsp}, 32'h00000002);
    rd_chk(`SOI_ADDR_ENABLE, 16'h00FF);
    complete_run();
  end
endmodule
